// File: hw/lsa_pkg.sv
// package of constants and types for the laser status annunciator
//
// Functional notes
// - power indicator steady green without supply/board fault
// - ready indicator yellow while enabled and fault free
// - tickle and pwm forwarded only while enabled
// - lasing indicator only for long enough pwm
// - normal nine-pin outputs follow lasing and ready
// - enable low turns ready, lasing, nine-pin off
// - over-temperature flashes ready, sets overtemp output
// - voltage fault blinks power, sets supply output
// - board fault flashes ready and power, outputs low except rj45 temperature and voltage ok
// - rj45 ok outputs high in normal operation
// - rj45 ok outputs drop on matching faults
// - blink code, half second pause, repeat
// - faults latch until reset
// - one, two, three blinks per voltage fault
// - enable loss is not latched
package lsa_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;                           // 100 MHz system clock
  localparam int TICK_PERIOD_NS = 1000000;                      // blink timebase, 1 ms
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS; // clocks per tick
  localparam int PAUSE_MS       = 500;                          // pause after a code
  localparam int BLINK_ON_MS    = 150;                          // lit part of one blink
  localparam int BLINK_OFF_MS   = 150;                          // dark part of one blink
  localparam int LASE_HOLD_MS   = 20;                           // lasing lamp hold after pulse
  localparam int TMR_W          = 10;                           // tick timer width
  localparam logic [TMR_W-1:0] PAUSE_TICKS    = TMR_W'(PAUSE_MS);
  localparam logic [TMR_W-1:0] BLINK_ON_TICKS = TMR_W'(BLINK_ON_MS);
  localparam logic [TMR_W-1:0] BLINK_OFF_TICKS = TMR_W'(BLINK_OFF_MS);
  localparam logic [TMR_W-1:0] LASE_HOLD_TICKS = TMR_W'(LASE_HOLD_MS);
  localparam int PWM_W          = 16;                           // pulse width counter width

  // ------------------------------------------------------------
  // blink codes and synchroniser bit positions
  // ------------------------------------------------------------
  typedef logic [1:0] lsa_code_t;
  localparam lsa_code_t CODE_NONE  = 2'h0;                      // no counted code
  localparam lsa_code_t CODE_UNDER = 2'h1;                      // under voltage
  localparam lsa_code_t CODE_OVER  = 2'h2;                      // over voltage
  localparam lsa_code_t CODE_SENSE = 2'h3;                      // supply sense fault
  localparam int N_PINS = 8;                                    // synchronised pins
  localparam int P_EN   = 0;
  localparam int P_TKL  = 1;
  localparam int P_PWM  = 2;
  localparam int P_UV   = 3;
  localparam int P_OV   = 4;
  localparam int P_DCS  = 5;
  localparam int P_OT   = 6;
  localparam int P_BRD  = 7;
  localparam logic [N_PINS-1:0] SYNC_RST = 8'h00;
  typedef enum {B_IDLE, B_ON, B_OFF, B_PAUSE} lsa_blink_e;
endpackage

// File: hw/lsa_blink_if.sv
// interface between annunciator core and a lamp blink sequencer
`timescale 1ns/100ps
interface lsa_blink_if;
  import lsa_pkg::*;
  logic      tick;   // one-cycle timebase pulse
  lsa_code_t code;   // counted blink code, none = not counted
  logic      flash;  // continuous flashing request
  logic      led;    // lamp drive from the sequencer
  modport ctrl (output tick, output code, output flash, input led);
  modport seq  (input tick, input code, input flash, output led);
endinterface

// File: hw/lsa_blinker.sv
// blink sequencer: counted codes with pause, or continuous flashing
`timescale 1ns/100ps
module lsa_blinker
(
  input  wire logic CLK_I,          // system clock
  input  wire logic RST_I,          // synchronous reset, high
  lsa_blink_if.seq  bl              // request and lamp drive
);
  import lsa_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  lsa_blink_e       state, next_state;  // sequencer phase
  logic [TMR_W-1:0] tmr, next_tmr;      // ticks spent in phase
  lsa_code_t        cnt, next_cnt;      // blinks shown so far
  logic             led, next_led;      // lamp flip-flop
  logic             req;                // any blinking wanted

  assign req    = bl.flash | (bl.code != CODE_NONE);
  assign bl.led = led;

  // next phase; a dropped request returns to dark idle at once
  always_comb
  begin
    next_state = state;
    next_tmr   = tmr;
    next_cnt   = cnt;
    next_led   = led;
    if (!req)
    begin
      next_state = B_IDLE;
      next_tmr   = '0;
      next_cnt   = CODE_NONE;
      next_led   = 1'b0;
    end
    else if (bl.tick)
    begin
      next_tmr = tmr + TMR_W'(1);
      case (state)
        B_IDLE:
        begin
          next_state = B_ON;
          next_tmr   = '0;
          next_led   = 1'b1;
        end
        B_ON:
        if (tmr + TMR_W'(1) >= BLINK_ON_TICKS)
        begin
          next_state = B_OFF;
          next_tmr   = '0;
          next_led   = 1'b0;
          next_cnt   = cnt + 2'h1;
        end
        B_OFF:
        if (tmr + TMR_W'(1) >= BLINK_OFF_TICKS)
        begin
          next_tmr = '0;
          // a counted code pauses after its last blink
          if (!bl.flash && cnt >= bl.code)
          begin
            next_state = B_PAUSE;
          end
          else
          begin
            next_state = B_ON;
            next_led   = 1'b1;
          end
        end
        B_PAUSE:
        if (tmr + TMR_W'(1) >= PAUSE_TICKS)
        begin
          next_state = B_ON;                          // repeat the code forever
          next_tmr   = '0;
          next_cnt   = CODE_NONE;
          next_led   = 1'b1;
        end
        default:
        begin
          next_state = B_IDLE;
          next_led   = 1'b0;
        end
      endcase
    end
  end

  // register the sequencer; lamp dark during reset
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      state <= B_IDLE;
      tmr   <= '0;
      cnt   <= CODE_NONE;
      led   <= 1'b0;
    end
    else
    begin
      state <= next_state;
      tmr   <= next_tmr;
      cnt   <= next_cnt;
      led   <= next_led;
    end
  end
endmodule

// File: hw/lsa_annunciator.sv
// laser status annunciator top: faults, lamps, status pins, command gating
`timescale 1ns/100ps
module lsa_annunciator
#(
  parameter int TICK_DIV = lsa_pkg::TICK_CYCLES      // clocks per 1 ms blink tick
)
(
  input  wire logic                     CLK_I,          // 100 MHz system clock
  input  wire logic                     RST_I,          // power-on reset, sync, high
  input  wire logic                     ENABLE_I,       // external laser enable pin
  input  wire logic                     TICKLE_I,       // tickle command pin
  input  wire logic                     PWM_I,          // pwm command pin
  input  wire logic                     UNDER_VOLT_I,   // under-voltage detect
  input  wire logic                     OVER_VOLT_I,    // over-voltage detect
  input  wire logic                     SENSE_FLT_I,    // supply sense fault detect
  input  wire logic                     OVER_TEMP_I,    // over-temperature detect
  input  wire logic                     BOARD_FLT_I,    // modulation sense/board fault
  input  wire logic [lsa_pkg::PWM_W-1:0] MIN_PWM_I,     // least lasing pulse, clocks
  output logic                          POWER_LED_O,    // power_indicator, green
  output logic                          READY_LED_O,    // ready lamp, yellow
  output logic                          LASE_LED_O,     // lasing lamp, red
  output logic                          LASE_STAT_O,    // nine-pin lasing status
  output logic                          READY_STAT_O,   // nine-pin ready status
  output logic                          OVERTEMP_STAT_O, // nine-pin over-temp status
  output logic                          SUPPLY_FAULT_OUT_O, // nine-pin supply_fault_out
  output logic                          LASER_OK_O,     // rj45 laser ok
  output logic                          TEMP_OK_O,      // rj45 temperature ok
  output logic                          VOLT_OK_O,      // rj45 voltage ok
  output logic                          RF_TICKLE_O,    // tickle to rf driver
  output logic                          RF_PWM_O        // pwm to rf driver
);
  import lsa_pkg::*;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [N_PINS-1:0] pins;       // raw asynchronous pins
  logic [N_PINS-1:0] meta;       // first stage, read only by second
  logic [N_PINS-1:0] sync;       // second stage, safe to use
  assign pins = {BOARD_FLT_I, OVER_TEMP_I, SENSE_FLT_I, OVER_VOLT_I,
                 UNDER_VOLT_I, PWM_I, TICKLE_I, ENABLE_I};

  // two flops per pin; every pin, command or detect, is treated as asynchronous
  genvar gi;
  generate
    for (gi = 0; gi < N_PINS; gi++)
    begin : g_sync
      always_ff @(posedge CLK_I)
      begin
        if (RST_I)
        begin
          meta[gi] <= SYNC_RST[gi];
          sync[gi] <= SYNC_RST[gi];
        end
        else
        begin
          meta[gi] <= pins[gi];
          sync[gi] <= meta[gi];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // tick divider, fault latches, pulse qualifier
  // ------------------------------------------------------------
  logic [31:0]      div, next_div;        // tick prescaler
  logic             tick, next_tick;      // 1 ms enable pulse
  logic             f_uv, next_f_uv;      // latched under-voltage
  logic             f_ov, next_f_ov;      // latched over-voltage
  logic             f_dcs, next_f_dcs;    // latched sense fault
  logic             f_ot, next_f_ot;      // latched over-temperature
  logic             f_brd, next_f_brd;    // latched board fault
  logic [PWM_W-1:0] pw, next_pw;          // current high time of pwm
  logic             lase, next_lase;      // qualified pwm activity
  logic [TMR_W-1:0] hold, next_hold;      // ticks since last long pulse
  logic             f_volt;               // any supply fault
  logic             fault;                // any latched fault
  logic             en;                   // live enable, never latched

  assign f_volt = f_uv | f_ov | f_dcs;
  assign fault  = f_volt | f_ot | f_brd;
  assign en     = sync[P_EN];

  // divider runs free so every lamp shares one timebase
  always_comb
  begin
    next_div  = div + 32'h1;
    next_tick = 1'b0;
    if (div >= 32'(TICK_DIV - 1))
    begin
      next_div  = 32'h0;
      next_tick = 1'b1;
    end
  end

  // faults only ever set; clearing needs the power-on reset
  always_comb
  begin
    next_f_uv  = f_uv  | sync[P_UV];
    next_f_ov  = f_ov  | sync[P_OV];
    next_f_dcs = f_dcs | sync[P_DCS];
    next_f_ot  = f_ot  | sync[P_OT];
    next_f_brd = f_brd | sync[P_BRD];
  end

  // a pulse counts once it has stayed high MIN_PWM_I clocks;
  // the lamp then holds briefly so a pulse train reads as steady
  always_comb
  begin
    next_pw   = pw;
    next_lase = lase;
    next_hold = hold;
    if (sync[P_PWM] && en && !fault)
    begin
      if (pw != {PWM_W{1'b1}})
      begin
        next_pw = pw + PWM_W'(1);
      end
    end
    else
    begin
      next_pw = '0;
    end
    if (sync[P_PWM] && en && !fault && pw >= MIN_PWM_I)
    begin
      next_lase = 1'b1;
      next_hold = '0;
    end
    else if (!en || fault)
    begin
      next_lase = 1'b0;
    end
    else if (tick && lase)
    begin
      next_hold = hold + TMR_W'(1);
      if (hold + TMR_W'(1) >= LASE_HOLD_TICKS)
      begin
        next_lase = 1'b0;
        next_hold = '0;
      end
    end
  end

  // register the core state
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      div   <= 32'h0;
      tick  <= 1'b0;
      f_uv  <= 1'b0;
      f_ov  <= 1'b0;
      f_dcs <= 1'b0;
      f_ot  <= 1'b0;
      f_brd <= 1'b0;
      pw    <= '0;
      lase  <= 1'b0;
      hold  <= '0;
    end
    else
    begin
      div   <= next_div;
      tick  <= next_tick;
      f_uv  <= next_f_uv;
      f_ov  <= next_f_ov;
      f_dcs <= next_f_dcs;
      f_ot  <= next_f_ot;
      f_brd <= next_f_brd;
      pw    <= next_pw;
      lase  <= next_lase;
      hold  <= next_hold;
    end
  end

  // ------------------------------------------------------------
  // blink sequencers for ready and power lamps
  // ------------------------------------------------------------
  lsa_blink_if rdy_bl ();
  lsa_blink_if pwr_bl ();

  assign rdy_bl.tick  = tick;
  assign rdy_bl.code  = CODE_NONE;
  assign rdy_bl.flash = f_brd | (f_ot & ~f_volt);
  assign pwr_bl.tick  = tick;
  // board fault flashes; otherwise the worst supply fault picks the count
  assign pwr_bl.flash = f_brd;
  assign pwr_bl.code  = f_brd ? CODE_NONE :
                        f_dcs ? CODE_SENSE :
                        f_ov  ? CODE_OVER  :
                        f_uv  ? CODE_UNDER : CODE_NONE;

  lsa_blinker u_rdy_blink
  (
    .CLK_I (CLK_I),
    .RST_I (RST_I),
    .bl    (rdy_bl)
  );

  lsa_blinker u_pwr_blink
  (
    .CLK_I (CLK_I),
    .RST_I (RST_I),
    .bl    (pwr_bl)
  );

  // ------------------------------------------------------------
  // registered lamps, status pins and command gating
  // ------------------------------------------------------------
  logic [11:0] outs, next_outs;   // all outputs in one register
  logic        ready_on;          // steady ready condition
  logic        ot_only;           // over-temp shown as its own fault
  assign ready_on = en & ~fault;
  assign ot_only  = f_ot & ~f_volt & ~f_brd;

  // every output is a flop so the pins never glitch on decode
  always_comb
  begin
    next_outs[0]  = (f_volt | f_brd) ? pwr_bl.led : 1'b1;
    next_outs[1]  = (f_brd | ot_only) ? rdy_bl.led : ready_on;
    next_outs[2]  = lase & ready_on;
    next_outs[3]  = lase & ready_on;
    next_outs[4]  = ready_on;
    next_outs[5]  = ot_only;
    next_outs[6]  = f_volt & ~f_brd;
    next_outs[7]  = ready_on;
    next_outs[8]  = ~f_ot;
    next_outs[9]  = ~f_volt;
    next_outs[10] = sync[P_TKL] & ready_on;
    next_outs[11] = sync[P_PWM] & ready_on;
  end

  // lamps off and pins low while reset is held
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      outs <= 12'h000;
    end
    else
    begin
      outs <= next_outs;
    end
  end

  assign POWER_LED_O        = outs[0];
  assign READY_LED_O        = outs[1];
  assign LASE_LED_O         = outs[2];
  assign LASE_STAT_O        = outs[3];
  assign READY_STAT_O       = outs[4];
  assign OVERTEMP_STAT_O    = outs[5];
  assign SUPPLY_FAULT_OUT_O = outs[6];
  assign LASER_OK_O         = outs[7];
  assign TEMP_OK_O          = outs[8];
  assign VOLT_OK_O          = outs[9];
  assign RF_TICKLE_O        = outs[10];
  assign RF_PWM_O           = outs[11];
endmodule

// File: sim/lsa_annunciator_asserts.sv
// port-level checker for the laser status annunciator
`timescale 1ns/100ps
module lsa_annunciator_asserts
#(
  parameter int TICK_DIV = 10         // blink tick divider, unused here
)
(
  input wire logic CLK_I,              // clock
  input wire logic RST_I,              // sync reset
  input wire logic ENABLE_I,           // enable pin
  input wire logic PWM_I,              // pwm pin
  input wire logic POWER_LED_O,        // power lamp
  input wire logic READY_LED_O,        // ready lamp
  input wire logic LASE_LED_O,         // lasing lamp
  input wire logic LASE_STAT_O,        // lasing status
  input wire logic READY_STAT_O,       // ready status
  input wire logic OVERTEMP_STAT_O,    // overtemp status
  input wire logic SUPPLY_FAULT_OUT_O, // supply fault status
  input wire logic LASER_OK_O,         // laser ok
  input wire logic TEMP_OK_O,          // temperature ok
  input wire logic VOLT_OK_O,          // voltage ok
  input wire logic RF_TICKLE_O,        // gated tickle
  input wire logic RF_PWM_O            // gated pwm
);
  // ------------------------------------------------------------
  // age since reset, so latch checks skip the boot edges
  // ------------------------------------------------------------
  logic [1:0] up_cnt;      // saturating age
  logic [1:0] next_up_cnt; // next age
  always_comb
  begin
    next_up_cnt = RST_I ? 2'h0 : ((up_cnt == 2'h3) ? up_cnt : up_cnt + 2'h1);
  end
  always_ff @(posedge CLK_I)
  begin
    up_cnt <= next_up_cnt;
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_release;
    $fell(RST_I);
  endsequence
  sequence s_lamps_up;
    ##[1:3] (POWER_LED_O && TEMP_OK_O && VOLT_OK_O);
  endsequence
  a_boot_lamps_on:
    assert property (s_release |-> s_lamps_up) else $error("lamps not up after reset");
  a_reset_quiet:
    assert property (@(posedge CLK_I) disable iff (1'b0) RST_I && $past(RST_I) |->
      !(POWER_LED_O | READY_LED_O | LASE_LED_O | TEMP_OK_O | VOLT_OK_O | RF_PWM_O))
      else $error("output lit during reset");
  a_enable_gate:
    assert property (!$past(ENABLE_I, 3) |-> !(READY_STAT_O | RF_PWM_O | RF_TICKLE_O
      | LASE_STAT_O)) else $error("enable low but outputs active");
  a_pwm_source:
    assert property (RF_PWM_O |-> $past(PWM_I, 3)) else $error("rf pwm without pwm pin");
  a_rf_needs_ready:
    assert property ((RF_PWM_O | RF_TICKLE_O | LASE_STAT_O) |-> READY_STAT_O)
      else $error("command passed while not ready");
  a_lase_pair:
    assert property (LASE_LED_O == LASE_STAT_O) else $error("lase lamp and status differ");
  a_laser_ok_track:
    assert property (LASER_OK_O == READY_STAT_O) else $error("laser ok differs from ready");
  a_overtemp_lines:
    assert property (OVERTEMP_STAT_O |-> !(READY_STAT_O | TEMP_OK_O | SUPPLY_FAULT_OUT_O))
      else $error("overtemp status lines wrong");
  a_supply_lines:
    assert property (SUPPLY_FAULT_OUT_O |-> !(VOLT_OK_O | READY_STAT_O | OVERTEMP_STAT_O))
      else $error("supply fault status lines wrong");
  a_temp_latched:
    assert property (up_cnt == 2'h3 && !TEMP_OK_O |=> !TEMP_OK_O)
      else $error("temperature fault cleared");
  a_volt_latched:
    assert property (up_cnt == 2'h3 && !VOLT_OK_O |=> !VOLT_OK_O)
      else $error("voltage fault cleared");
endmodule
bind lsa_annunciator lsa_annunciator_asserts #(.TICK_DIV(TICK_DIV)) lsa_chk (.CLK_I(CLK_I),
  .RST_I(RST_I), .ENABLE_I(ENABLE_I), .PWM_I(PWM_I), .POWER_LED_O(POWER_LED_O),
  .READY_LED_O(READY_LED_O), .LASE_LED_O(LASE_LED_O), .LASE_STAT_O(LASE_STAT_O),
  .READY_STAT_O(READY_STAT_O), .OVERTEMP_STAT_O(OVERTEMP_STAT_O),
  .SUPPLY_FAULT_OUT_O(SUPPLY_FAULT_OUT_O), .LASER_OK_O(LASER_OK_O), .TEMP_OK_O(TEMP_OK_O),
  .VOLT_OK_O(VOLT_OK_O), .RF_TICKLE_O(RF_TICKLE_O), .RF_PWM_O(RF_PWM_O));

// File: sim/lsa_ctrl_model.sv
// machine controller model driving enable and command pins
`timescale 1ns/100ps
module lsa_ctrl_model
(
  input  wire logic clk_i,    // system clock
  output logic      enable_o, // laser enable
  output logic      tickle_o, // tickle command
  output logic      pwm_o     // pwm command
);
  // all lines idle from time zero
  initial
  begin
    enable_o = 1'b0;
    tickle_o = 1'b0;
    pwm_o = 1'b0;
  end
  // change lines just after an edge, held until the next call
  task automatic set_lines(input logic en, input logic tk, input logic pw);
    @(posedge clk_i);
    enable_o <= en;
    tickle_o <= tk;
    pwm_o <= pw;
  endtask
endmodule

// File: sim/lsa_annunciator_bench.sv
// self-checking bench for the laser status annunciator
`timescale 1ns/100ps
module lsa_annunciator_bench;
  import lsa_pkg::*;
  localparam int MS = 10;                         // clocks per blink tick in sim
  logic             clk;                          // system clock
  logic             rst;                          // sync reset
  logic             en;                           // enable from model
  logic             tk;                           // tickle from model
  logic             pw;                           // pwm from model
  logic [4:0]       flt;                          // board,temp,sense,over,under
  logic [PWM_W-1:0] min_pwm;                      // least lasing width
  logic [11:0]      outs;                         // all status outputs
  int               bad_count;                    // mismatches
  int               samples_checked;              // comparisons
  int               np;                           // power lamp falls
  int               nr;                           // ready lamp falls
  lsa_annunciator #(.TICK_DIV(MS)) lsa_annunciator_inst (.CLK_I(clk), .RST_I(rst),
    .ENABLE_I(en), .TICKLE_I(tk), .PWM_I(pw), .UNDER_VOLT_I(flt[0]), .OVER_VOLT_I(flt[1]),
    .SENSE_FLT_I(flt[2]), .OVER_TEMP_I(flt[3]), .BOARD_FLT_I(flt[4]), .MIN_PWM_I(min_pwm),
    .POWER_LED_O(outs[11]), .READY_LED_O(outs[10]), .LASE_LED_O(outs[9]),
    .LASE_STAT_O(outs[8]), .READY_STAT_O(outs[7]), .OVERTEMP_STAT_O(outs[6]),
    .SUPPLY_FAULT_OUT_O(outs[5]), .LASER_OK_O(outs[4]), .TEMP_OK_O(outs[3]),
    .VOLT_OK_O(outs[2]), .RF_TICKLE_O(outs[1]), .RF_PWM_O(outs[0]));
  lsa_ctrl_model lsa_ctrl_model_inst (.clk_i(clk), .enable_o(en), .tickle_o(tk), .pwm_o(pw));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // wait n edges, then sample once the edge has settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic miss(input string msg);
    bad_count++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask
  // compare the cared bits of all outputs; unknowns never match
  task automatic check(input logic [11:0] exp, input logic [11:0] care, input string msg);
    samples_checked++;
    if (((outs ^ exp) & care) !== 12'h000)
      miss(msg);
  endtask
  task automatic chk_n(input int got, input int exp, input string msg);
    samples_checked++;
    if (got != exp)
      miss(msg);
  endtask
  // count falling edges of both lamps; falls survive a lamp that starts lit
  task automatic cnt(input int n, output int fp, output int fr);
    logic lp;
    logic lr;
    fp = 0;
    fr = 0;
    lp = outs[11];
    lr = outs[10];
    repeat (n)
    begin
      cyc(1);
      if (lp === 1'b1 && outs[11] === 1'b0) fp++;
      if (lr === 1'b1 && outs[10] === 1'b0) fr++;
      lp = outs[11];
      lr = outs[10];
    end
  endtask
  task automatic raise(input int i);
    @(posedge clk);
    flt <= 5'h01 << i;
  endtask
  // faults latch, so each supply and board fault scenario starts from a fresh reset
  task automatic do_reset();
    lsa_ctrl_model_inst.set_lines(1'b0, 1'b0, 1'b0);
    rst <= 1'b1;
    flt <= 5'h00;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    cyc(4);
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    flt = 5'h00;
    min_pwm = 16'h0014;
    bad_count = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    cyc(4);
    check(12'h80C, 12'hFFF, "idle after reset");
    lsa_ctrl_model_inst.set_lines(1'b1, 1'b0, 1'b0);
    cyc(5);
    check(12'hC9C, 12'hFFF, "enabled idle");
    lsa_ctrl_model_inst.set_lines(1'b1, 1'b1, 1'b0);
    cyc(60);
    check(12'hC9E, 12'hFFF, "tickle only");
    lsa_ctrl_model_inst.set_lines(1'b1, 1'b0, 1'b1);
    cyc(9);
    lsa_ctrl_model_inst.set_lines(1'b1, 1'b0, 1'b0);
    cyc(30);
    check(12'hC9C, 12'hFFF, "short pwm lit lase");
    lsa_ctrl_model_inst.set_lines(1'b1, 1'b0, 1'b1);
    for (int i = 0; i < 200 && outs[9] !== 1'b1; i++)
      cyc(1);
    if (outs[9] !== 1'b1)
    begin
      miss("lase lamp never lit");
      stop_test();
    end
    cyc(2);
    check(12'hF9D, 12'hFFF, "pwm lasing");
    // pwm stops: the lasing lamp holds for the hold time, then goes dark
    lsa_ctrl_model_inst.set_lines(1'b1, 1'b0, 1'b0);
    cyc(5);
    check(12'hF9C, 12'hFFF, "lase lamp not held");
    cyc(20 * MS + 40);
    check(12'hC9C, 12'hFFF, "lase hold not expired");
    lsa_ctrl_model_inst.set_lines(1'b0, 1'b0, 1'b1);
    cyc(5);
    check(12'h80C, 12'hFFF, "enable removed");
    lsa_ctrl_model_inst.set_lines(1'b1, 1'b0, 1'b1);
    cyc(5);
    check(12'hC9D, 12'hCFF, "enable restored");
    lsa_ctrl_model_inst.set_lines(1'b1, 1'b0, 1'b0);
    cyc(20 * MS + 40);
    check(12'hC9C, 12'hFFF, "lase hold expired");
    lsa_ctrl_model_inst.set_lines(1'b1, 1'b1, 1'b1);
    raise(3);
    repeat (3) @(posedge clk);
    flt <= 5'h00;
    cyc(6);
    check(12'h844, 12'hBFF, "over temperature");
    cnt(600 * MS, np, nr);
    chk_n(nr, 2, "ready flash count");
    chk_n(np, 0, "power lamp blinked");
    check(12'h844, 12'hBFF, "over temperature kept");
    for (int k = 1; k <= 3; k++)
    begin
      do_reset();
      lsa_ctrl_model_inst.set_lines(1'b1, 1'b0, 1'b0);
      cyc(5);
      raise(k - 1);
      cnt(2 * (k * 300 + 500) * MS, np, nr);
      // the steady power lamp drops once as the fault latches, then two codes follow
      chk_n(np, 2 * k + 1, "supply blink code");
      chk_n(nr, 1, "ready lamp not off");
      @(posedge clk);
      flt <= 5'h00;
      cyc(6);
      check(12'h028, 12'h7FF, "supply fault");
    end
    do_reset();
    lsa_ctrl_model_inst.set_lines(1'b1, 1'b1, 1'b1);
    raise(4);
    cyc(8);
    check(12'h00C, 12'h3FF, "board fault");
    cnt(600 * MS, np, nr);
    chk_n(np, 2, "power flash count");
    chk_n(nr, 2, "ready flash count");
    stop_test();
  end
endmodule
